// ===== hw/sar_conversion_sequencer.sv
// conversion sequencer for the 18-bit successive-approximation core
`timescale 1ns/10ps
module sar_conversion_sequencer
#(
  parameter int unsigned ACQ_CYCLES = sar_seq_pkg::ACQ_CYCLES
)
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_conversion_start_n,
  input  wire logic        i_coding_select_pin,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_hw_config,
  input  wire logic [1:0]  i_range_pins,
  input  wire logic [2:0]  i_cfg_reg,
  input  wire logic        i_comparator_high,
  input  wire logic        i_over_range,
  input  wire logic        i_under_range,
  output logic             o_busy,
  output logic             o_pos_array_ground_switch,
  output logic             o_neg_array_ground_switch,
  output logic             o_array_to_input,
  output logic             o_array_to_reference_ground,
  output logic [17:0]      o_dac_trial,
  output logic [1:0]       o_range,
  output logic [17:0]      o_code,
  output logic             o_code_valid
);
  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [1:0] cnv_sync_q;
  logic [1:0] cmp_sync_q;
  logic       cnv_prev_q;
  logic       cnv_fall_w;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
    begin
      cnv_sync_q <= 2'h3;
      cmp_sync_q <= 2'h0;
      cnv_prev_q <= 1'b1;
    end
    else
    begin
      cnv_sync_q <= {cnv_sync_q[0], i_conversion_start_n};
      cmp_sync_q <= {cmp_sync_q[0], i_comparator_high};
      cnv_prev_q <= cnv_sync_q[1];
    end

  assign cnv_fall_w = cnv_prev_q & ~cnv_sync_q[1];

  // ***************************************************************
  // configuration pin synchronisers
  // ***************************************************************
  // strap pins are slow but still asynchronous, so two stages each
  logic [1:0] mode_s1_q;
  logic [1:0] mode_s2_q;
  logic       hw_s1_q;
  logic       hw_s2_q;
  logic [1:0] rng_s1_q;
  logic [1:0] rng_s2_q;
  logic       cod_s1_q;
  logic       cod_s2_q;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
    begin
      mode_s1_q <= sar_seq_pkg::MODE_PAR18;
      mode_s2_q <= sar_seq_pkg::MODE_PAR18;
      hw_s1_q   <= 1'b1;
      hw_s2_q   <= 1'b1;
      rng_s1_q  <= sar_seq_pkg::RANGE_RESET;
      rng_s2_q  <= sar_seq_pkg::RANGE_RESET;
      cod_s1_q  <= 1'b1;
      cod_s2_q  <= 1'b1;
    end
    else
    begin
      mode_s1_q <= i_mode;
      mode_s2_q <= mode_s1_q;
      hw_s1_q   <= i_hw_config;
      hw_s2_q   <= hw_s1_q;
      rng_s1_q  <= i_range_pins;
      rng_s2_q  <= rng_s1_q;
      cod_s1_q  <= i_coding_select_pin;
      cod_s2_q  <= cod_s1_q;
    end

  // ***************************************************************
  // configuration selection
  // ***************************************************************
  logic       sw_mode_w;
  logic [1:0] range_sel_w;
  logic       coding_sel_w;
  logic       coding_q;
  logic       ob_w;

  assign sw_mode_w = (mode_s2_q == sar_seq_pkg::MODE_SERIAL) & ~hw_s2_q;
  assign range_sel_w = sw_mode_w ? i_cfg_reg[sar_seq_pkg::CFG_RANGE_LSB +: 2] : rng_s2_q;
  assign coding_sel_w = sw_mode_w ? i_cfg_reg[sar_seq_pkg::CFG_CODING_BIT]
                                  : cod_s2_q;

  // ***************************************************************
  // sequencer
  // ***************************************************************
  sar_seq_pkg::seq_state_t state_q;
  sar_seq_pkg::seq_state_t state_d;
  logic [7:0]  acq_cnt_q;
  logic        acq_done_w;
  logic [17:0] code_q;
  logic        valid_q;
  logic [17:0] sb_code_w;
  logic [17:0] out_code_w;

  sar_array_if arr ();

  sar_approx_reg u_sar
  (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .bus       (arr.sar)
  );

  assign acq_done_w = (acq_cnt_q >= 8'(ACQ_CYCLES));

  assign arr.start    = (state_q == sar_seq_pkg::ST_HOLD);
  assign arr.step     = (state_q == sar_seq_pkg::ST_TRIAL);
  assign arr.cmp_high = cmp_sync_q[1];

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sar_seq_pkg::ST_ACQ:
        if (acq_done_w)
          state_d = sar_seq_pkg::ST_READY;
      sar_seq_pkg::ST_READY:
        if (cnv_fall_w)
          state_d = sar_seq_pkg::ST_OPEN;
      sar_seq_pkg::ST_OPEN:
        state_d = sar_seq_pkg::ST_HOLD;
      sar_seq_pkg::ST_HOLD:
        state_d = sar_seq_pkg::ST_TRIAL;
      sar_seq_pkg::ST_TRIAL:
        if (arr.last)
          state_d = sar_seq_pkg::ST_FORM;
      sar_seq_pkg::ST_FORM:
        state_d = sar_seq_pkg::ST_ACQ;
      default:
        state_d = sar_seq_pkg::ST_ACQ;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
      state_q <= sar_seq_pkg::ST_ACQ;
    else
      state_q <= state_d;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
      acq_cnt_q <= 8'h00;
    else if (state_q != sar_seq_pkg::ST_ACQ)
      acq_cnt_q <= 8'h00;
    else if (!acq_done_w)
      acq_cnt_q <= acq_cnt_q + 8'h01;

  // ***************************************************************
  // state decode
  // ***************************************************************
  logic st_acq_w;
  logic st_ready_w;
  logic st_open_w;
  logic st_trial_w;
  logic st_form_w;
  logic latch_cfg_w;
  logic ground_closed_w;

  function automatic logic in_state(input sar_seq_pkg::seq_state_t cur,
                                    input sar_seq_pkg::seq_state_t want);
    in_state = (cur == want);
  endfunction

  assign st_acq_w    = in_state(state_q, sar_seq_pkg::ST_ACQ);
  assign st_ready_w  = in_state(state_q, sar_seq_pkg::ST_READY);
  assign st_open_w   = in_state(state_q, sar_seq_pkg::ST_OPEN);
  assign st_trial_w  = in_state(state_q, sar_seq_pkg::ST_TRIAL);
  assign st_form_w   = in_state(state_q, sar_seq_pkg::ST_FORM);
  // setting taken once, at the end of each acquisition
  assign latch_cfg_w = st_acq_w & acq_done_w;

  // ***************************************************************
  // configuration latch and output coding
  // ***************************************************************
  // latch config per acquisition
  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
    begin
      o_range  <= sar_seq_pkg::RANGE_RESET;
      coding_q <= 1'b1;
    end
    else if (latch_cfg_w)
    begin
      o_range  <= range_sel_w;
      coding_q <= coding_sel_w;
    end

  assign ob_w = (mode_s2_q == sar_seq_pkg::MODE_PAR18) ? 1'b1 : coding_q;

  // over wins if both flags rise; comparator word is then discarded
  function automatic logic [17:0] clamp_code(input logic [17:0] raw,
                                             input logic        over,
                                             input logic        under);
    if (over)
      clamp_code = sar_seq_pkg::SB_MAX;
    else if (under)
      clamp_code = sar_seq_pkg::SB_MIN;
    else
      clamp_code = raw;
  endfunction

  function automatic logic [17:0] apply_coding(input logic [17:0] sb,
                                               input logic        binary);
    apply_coding = binary ? sb : {~sb[17], sb[16:0]};
  endfunction

  assign sb_code_w  = clamp_code(arr.result, i_over_range, i_under_range);
  assign out_code_w = apply_coding(sb_code_w, ob_w);

  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
    begin
      code_q  <= sar_seq_pkg::CODE_RESET;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= st_form_w;
      if (st_form_w)
        code_q <= out_code_w;
    end

  // ***************************************************************
  // switch and status outputs
  // ***************************************************************
  // ground switches open first
  assign ground_closed_w             = st_acq_w | st_ready_w;
  assign o_pos_array_ground_switch   = ground_closed_w;
  assign o_neg_array_ground_switch   = ground_closed_w;
  // inputs stay on the arrays for one cycle after the switches open
  assign o_array_to_input            = ground_closed_w | st_open_w;
  assign o_array_to_reference_ground = ~o_array_to_input;
  assign o_dac_trial  = st_trial_w ? arr.trial : 18'h00000;
  // busy falls in the cycle the formed code appears
  assign o_busy       = ~ground_closed_w;
  assign o_code       = code_q;
  assign o_code_valid = valid_q;
endmodule

// ===== hw/sar_seq_pkg.sv
// constants and types shared by the conversion sequencer
package sar_seq_pkg;
  localparam int unsigned        RES_BITS        = 18;
  localparam int unsigned        CLK_HZ          = 10000000;
  localparam int unsigned        SAMPLE_RATE_SPS = 250000;
  localparam int unsigned        ACQ_TIME_NS     = 1000;
  localparam int unsigned        CLK_PERIOD_NS   = 100;
  localparam int unsigned        ACQ_CYCLES      = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned        SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_SPS;
  localparam logic [17:0]        CODE_RESET      = 18'h00000;
  localparam logic [17:0]        SB_MAX          = 18'h3ffff;
  localparam logic [17:0]        SB_MIN          = 18'h00000;
  localparam logic [17:0]        TC_MAX          = 18'h1ffff;
  localparam logic [17:0]        TC_MIN          = 18'h20000;
  localparam logic [1:0]         MODE_PAR18      = 2'h0;
  localparam logic [1:0]         MODE_SERIAL     = 2'h3;
  localparam logic [1:0]         RANGE_RESET     = 2'h0;
  localparam int unsigned        CFG_RANGE_LSB   = 0;
  localparam int unsigned        CFG_CODING_BIT  = 2;

  typedef enum logic [2:0] {
    ST_ACQ    = 3'b000,
    ST_READY  = 3'b001,
    ST_OPEN   = 3'b010,
    ST_HOLD   = 3'b011,
    ST_TRIAL  = 3'b100,
    ST_FORM   = 3'b101
  } seq_state_t;
endpackage

// ===== hw/sar_array_if.sv
// analog array control and comparator between sequencer and sar register
`timescale 1ns/10ps
interface sar_array_if;
  logic        start;
  logic        step;
  logic        cmp_high;
  logic [17:0] trial;
  logic [17:0] result;
  logic        last;
  modport ctrl (output start, output step, output cmp_high, input trial, input result, input last);
  modport sar  (input start, input step, input cmp_high, output trial, output result, output last);
endinterface

// ===== hw/sar_approx_reg.sv
// binary-search register over the weighted array, msb first
`timescale 1ns/10ps
module sar_approx_reg
(
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  sar_array_if.sar  bus
);
  logic [17:0] mask_q;
  logic [17:0] code_q;
  logic [17:0] trial_w;

  assign trial_w    = code_q | mask_q;
  assign bus.trial  = trial_w;
  assign bus.result = code_q;
  assign bus.last   = mask_q[0];

  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
    begin
      mask_q <= 18'h00000;
      code_q <= 18'h00000;
    end
    else if (bus.start)
    begin
      mask_q <= 18'h20000;
      code_q <= 18'h00000;
    end
    else if (bus.step)
    begin
      // keep the element while input still exceeds the trial level
      if (bus.cmp_high)
        code_q <= trial_w;
      mask_q <= mask_q >> 1;
    end
endmodule

// ===== verif/sar_seq_properties.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/10ps
module sar_seq_properties
(
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_conversion_start_n,
  input wire logic        i_over_range,
  input wire logic        i_under_range,
  input wire logic        o_busy,
  input wire logic        o_pos_array_ground_switch,
  input wire logic        o_neg_array_ground_switch,
  input wire logic        o_array_to_input,
  input wire logic        o_array_to_reference_ground,
  input wire logic [17:0] o_dac_trial,
  input wire logic [17:0] o_code,
  input wire logic        o_code_valid
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // ***********
  // assertions
  // ***********
  chk_start_cause: assert property ($rose(o_busy) |-> !$past(i_conversion_start_n, 3))
    else $error("busy rose without a start request");
  chk_switch_first: assert property ($rose(o_busy) |-> !o_pos_array_ground_switch
    && o_array_to_input ##1 o_array_to_reference_ground)
    else $error("switch order wrong at conversion start");
  chk_switch_pair: assert property (o_neg_array_ground_switch == o_pos_array_ground_switch)
    else $error("ground switches out of step");
  chk_trial_msb: assert property ($rose(o_busy) |-> ##2 o_dac_trial == 18'h20000)
    else $error("first trial is not the top element");
  chk_busy_len: assert property ($rose(o_busy) |-> ##[19:21] $fell(o_busy))
    else $error("busy length does not fit 18 decisions");
  chk_code_after: assert property ($fell(o_busy) |-> o_code_valid)
    else $error("code not delivered as busy fell");
  chk_valid_pulse: assert property (o_code_valid |=> !o_code_valid)
    else $error("valid longer than one cycle");
  chk_code_hold: assert property ($changed(o_code) |-> o_code_valid)
    else $error("code changed without valid");
  chk_conv_time: assert property ($rose(o_busy) |-> ##[19:22] o_code_valid)
    else $error("conversion too slow");
  chk_over_max: assert property (o_code_valid && $past(i_over_range)
    && !$past(i_under_range) |-> o_code == 18'h3ffff || o_code == 18'h1ffff)
    else $error("overrange not saturated");
  chk_under_min: assert property (o_code_valid && $past(i_under_range)
    && !$past(i_over_range) |-> o_code == 18'h00000 || o_code == 18'h20000)
    else $error("underrange not saturated");
  cover property ($fell(o_busy));
  cover property (o_code_valid && o_code == 18'h3ffff);
  cover property (o_code_valid && i_under_range);
endmodule
bind sar_conversion_sequencer sar_seq_properties u_props
(
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_conversion_start_n(i_conversion_start_n),
  .i_over_range(i_over_range), .i_under_range(i_under_range), .o_busy(o_busy),
  .o_pos_array_ground_switch(o_pos_array_ground_switch),
  .o_neg_array_ground_switch(o_neg_array_ground_switch), .o_array_to_input(o_array_to_input),
  .o_array_to_reference_ground(o_array_to_reference_ground), .o_dac_trial(o_dac_trial),
  .o_code(o_code), .o_code_valid(o_code_valid)
);

// ===== verif/sar_host_model.sv
// host model: start strobe and comparator level
`timescale 1ns/10ps
module sar_host_model
(
  input  wire logic i_clk_sys,
  input  wire logic i_valid,
  output logic      o_start_n,
  output logic      o_cmp
);
  initial o_start_n = 1'b1;
  initial o_cmp = 1'b0;
  task automatic convert(input logic cmp, output logic ok);
    int n;
    ok = 1'b0;
    // gap covers acquisition plus sync delay
    repeat (16) @(negedge i_clk_sys);
    o_cmp = cmp;
    o_start_n = 1'b0;
    for (n = 0; n < 60 && !ok; n++)
    begin
      @(negedge i_clk_sys);
      ok = (i_valid === 1'b1);
    end
    o_start_n = 1'b1;
  endtask
endmodule

// ===== verif/test_sar_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module test_sar_conversion_sequencer;
  logic        clk, rstn, pin, hw, ov, un, start_n, cmp, vld, ok;
  logic [1:0]  mode, rp, rng;
  logic [2:0]  cfg;
  logic [17:0] code;
  int          err_count, cmp_count;
  sar_conversion_sequencer dut
  (
    .i_clk_sys(clk), .i_rstn(rstn), .i_conversion_start_n(start_n),
    .i_coding_select_pin(pin), .i_mode(mode), .i_hw_config(hw), .i_range_pins(rp),
    .i_cfg_reg(cfg), .i_comparator_high(cmp), .i_over_range(ov), .i_under_range(un),
    .o_busy(), .o_pos_array_ground_switch(), .o_neg_array_ground_switch(),
    .o_array_to_input(), .o_array_to_reference_ground(), .o_dac_trial(),
    .o_range(rng), .o_code(code), .o_code_valid(vld)
  );
  sar_host_model host (.i_clk_sys(clk), .i_valid(vld), .o_start_n(start_n), .o_cmp(cmp));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // two conversions: the setting is in force by the second
  task automatic cv(input logic [1:0] m, input logic h, p, input logic [1:0] r,
                    input logic [2:0] c, input logic k, o, u);
    @(negedge clk);
    mode = m; hw = h; pin = p; rp = r; cfg = c; ov = o; un = u;
    repeat (2)
    begin
      host.convert(k, ok);
      if (!ok)
      begin
        err_count++;
        give_verdict();
      end
    end
  endtask
  // ***********
  // scenarios
  // ***********
  task automatic t_pins();
    cv(2'h3, 1'b1, 1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    chk("zero code", 18'h00000, code);
    cv(2'h3, 1'b1, 1'b1, 2'h1, 3'h7, 1'b1, 1'b0, 1'b0);
    chk("full code", 18'h3ffff, code);
    chk("pin range", 18'(2'h1), 18'(rng));
    cv(2'h3, 1'b1, 1'b0, 2'h2, 3'h0, 1'b1, 1'b0, 1'b0);
    chk("pin twos", 18'h1ffff, code);
    chk("new range", 18'(2'h2), 18'(rng));
  endtask
  task automatic t_cfg();
    cv(2'h3, 1'b0, 1'b1, 2'h0, 3'h3, 1'b1, 1'b0, 1'b0);
    chk("cfg twos", 18'h1ffff, code);
    chk("cfg range", 18'(2'h3), 18'(rng));
    cv(2'h3, 1'b0, 1'b0, 2'h1, 3'h6, 1'b0, 1'b0, 1'b0);
    chk("cfg binary", 18'h00000, code);
    chk("cfg range2", 18'(2'h2), 18'(rng));
  endtask
  task automatic t_par();
    cv(2'h0, 1'b1, 1'b0, 2'h1, 3'h0, 1'b0, 1'b0, 1'b0);
    chk("par binary", 18'h00000, code);
  endtask
  task automatic t_clamp();
    cv(2'h3, 1'b1, 1'b1, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    chk("over bin", 18'h3ffff, code);
    cv(2'h3, 1'b1, 1'b0, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    chk("over twos", 18'h1ffff, code);
    cv(2'h3, 1'b1, 1'b0, 2'h0, 3'h0, 1'b1, 1'b0, 1'b1);
    chk("under twos", 18'h20000, code);
    cv(2'h3, 1'b1, 1'b1, 2'h0, 3'h0, 1'b1, 1'b0, 1'b1);
    chk("under bin", 18'h00000, code);
  endtask
  initial
  begin
    err_count = 0;
    cmp_count = 0;
    rstn = 1'b0;
    {pin, hw, ov, un, mode, rp, cfg} = '0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_pins();
    t_cfg();
    t_par();
    t_clamp();
    give_verdict();
  end
endmodule
